/* include/asfr_map.svh */
// register offsets, field positions and reset values of the sample readout block
`ifndef ASFR_MAP_SVH
`define ASFR_MAP_SVH
`define ASFR_STATUS_ADDR 8'h00
`define ASFR_X_HIGH_ADDR 8'h01
`define ASFR_X_LOW_ADDR 8'h02
`define ASFR_Y_HIGH_ADDR 8'h03
`define ASFR_Y_LOW_ADDR 8'h04
`define ASFR_Z_HIGH_ADDR 8'h05
`define ASFR_Z_LOW_ADDR 8'h06
`define ASFR_SETUP_ADDR 8'h09
`define ASFR_SETUP_RESET 8'h00
`define ASFR_MODE_HI 7
`define ASFR_MODE_LO 6
`define ASFR_WMRK_HI 5
`define ASFR_WMRK_LO 0
`define ASFR_SAMPLE_BITS 14
`define ASFR_FIFO_DEPTH 32
`define ASFR_BYTES_FULL 3'd5
`define ASFR_BYTES_FAST 3'd4
`endif

/* include/asfr_pkg.sv */
// types shared by the sample readout block
package asfr_pkg;
	// one xyz sample, 14 bits per axis, two's complement
	typedef struct packed {
		logic [13:0] x;
		logic [13:0] y;
		logic [13:0] z;
	} asfr_sample_t;
	// fifo operating mode in field encoding order 00..11
	typedef enum logic [1:0] {
		mode_off,
		mode_circular,
		mode_stop,
		mode_trigger
	} asfr_fifo_mode_t;
	// one byte-level register access from the serial front end
	typedef struct packed {
		logic start;
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} asfr_bus_t;
endpackage : asfr_pkg

/* rtl/asfr_readout.sv */
// sample fifo and register readout path of the accelerometer
`timescale 1ns/100ps
`default_nettype none
`include "asfr_map.svh"

// sample buffer with flush and simultaneous push/pop
module asfr_fifo #(
	parameter int WIDTH = 42,
	parameter int DEPTH = `ASFR_FIFO_DEPTH,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [CW-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic full;
	logic wr_go;
	logic rd_go;

	// a full buffer still takes a word when the head leaves that cycle
	assign full = (count == CW'(DEPTH));
	assign in_ready = !full || out_ready;
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign wr_go = in_valid && in_ready && !flush;
	assign rd_go = out_valid && out_ready && !flush;

	// storage carries no reset, only the pointers and the count do
	always_ff @(posedge mclk) begin
		if (clk_en && wr_go) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// write pointer with wrap at depth
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr <= '0;
		end else if (clk_en) begin
			if (flush) begin
				wr_ptr <= '0;
			end else if (wr_go) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
		end
	end

	// read pointer with wrap at depth
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_ptr <= '0;
		end else if (clk_en) begin
			if (flush) begin
				rd_ptr <= '0;
			end else if (rd_go) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	// occupancy
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
		end else if (clk_en) begin
			if (flush) begin
				count <= '0;
			end else if (wr_go && !rd_go) begin
				count <= count + 1'b1;
			end else if (rd_go && !wr_go) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : asfr_fifo

module asfr_readout #(
	parameter int DEPTH = `ASFR_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire asfr_pkg::asfr_bus_t bus,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire asfr_pkg::asfr_sample_t sample_in,
	input wire logic active_rate_tick,
	input wire logic sleep_rate_tick,
	input wire logic auto_sleep,
	input wire logic active_mode,
	input wire logic fifo_hold_on_sleep,
	input wire logic fast_read_sel,
	input wire logic trig_pulse,
	output logic push_stall,
	output logic overflow_flag,
	output logic watermark_flag,
	output logic hold_error,
	output logic [5:0] fifo_count
);
	import asfr_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);
	logic [7:0] setup;
	asfr_fifo_mode_t mode;
	logic [5:0] wmrk;
	logic fifo_on;
	asfr_sample_t cur_sample;
	asfr_sample_t frame;
	asfr_sample_t head;
	logic head_valid;
	logic [CW-1:0] count;
	logic [7:0] ptr;
	logic [2:0] idx;
	logic sleep_prev;
	logic active_prev;
	logic trig_seen;
	logic data_ready;
	logic tick;
	logic flush;
	logic sleep_enter;
	logic push_valid;
	logic push_ready;
	logic host_pop;
	logic drop;
	logic [CW-1:0] cap;
	logic [7:0] rd_byte;
	logic do_pop;
	logic [7:0] next_ptr;
	logic [2:0] next_idx;
	logic stream;

	// byte of a sample by index 0..5: even high, odd low
	function automatic logic [7:0] pick(input asfr_sample_t s, input logic [2:0] i);
		logic [13:0] a;
		a = (i[2:1] == 2'd0) ? s.x : (i[2:1] == 2'd1) ? s.y : s.z;
		pick = i[0] ? {a[5:0], 2'b00} : a[13:6];
	endfunction : pick

	// setup field decode
	assign mode = asfr_fifo_mode_t'(setup[`ASFR_MODE_HI:`ASFR_MODE_LO]);
	assign wmrk = setup[`ASFR_WMRK_HI:`ASFR_WMRK_LO];
	assign fifo_on = (mode != mode_off);

	// fifo rate follows the sleep state
	assign tick = auto_sleep ? sleep_rate_tick : active_rate_tick;

	// a held buffer survives the rate change so the host can drain it
	assign sleep_enter = auto_sleep && !sleep_prev;
	assign flush = !fifo_on
		|| ((auto_sleep != sleep_prev) && !hold_error
		&& !(sleep_enter && fifo_hold_on_sleep))
		|| (active_mode && !active_prev);

	// pre-trigger depth: the watermark, or the whole buffer when zero
	assign cap = (mode == mode_trigger && !trig_seen && wmrk != '0)
		? CW'(wmrk) : CW'(DEPTH);

	// push each rate tick unless hold_error is set; refusal only in stop and post-trigger modes
	assign push_valid = fifo_on && tick && !hold_error;
	assign host_pop = bus.rd && do_pop;
	assign drop = push_valid && !host_pop && count >= cap
		&& (mode == mode_circular || (mode == mode_trigger && !trig_seen));
	assign push_stall = push_valid && !push_ready;

	asfr_fifo #(
		.WIDTH($bits(asfr_sample_t)),
		.DEPTH(DEPTH),
		.CW(CW)
	) u_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.flush(flush),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(sample_in),
		.out_valid(head_valid),
		.out_ready(host_pop || drop),
		.out_data(head),
		.count(count)
	);
	assign fifo_count = 6'(count);

	// edge memories for flush detection
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sleep_prev <= 1'b0;
			active_prev <= 1'b0;
		end else if (clk_en) begin
			sleep_prev <= auto_sleep;
			active_prev <= active_mode;
		end
	end

	// setup register; switching between modes goes through off by host discipline
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			setup <= `ASFR_SETUP_RESET;
		end else if (clk_en && bus.wr && ptr == `ASFR_SETUP_ADDR) begin
			setup <= bus.wdata;
		end
	end

	// trigger latch; a trigger in a flush cycle is kept
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			trig_seen <= 1'b0;
		end else if (clk_en) begin
			if (trig_pulse && mode == mode_trigger) begin
				trig_seen <= 1'b1;
			end else if (flush) begin
				trig_seen <= 1'b0;
			end
		end
	end

	// buffer flags
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			overflow_flag <= 1'b0;
			watermark_flag <= 1'b0;
		end else if (clk_en) begin
			if (flush) begin
				overflow_flag <= 1'b0;
				watermark_flag <= 1'b0;
			end else begin
				if (count == CW'(DEPTH)) begin
					overflow_flag <= 1'b1;
				end
				watermark_flag <= (wmrk != '0) && (count >= CW'(wmrk));
			end
		end
	end

	// hold error: set on sleep entry with hold, cleared once emptied
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_error <= 1'b0;
		end else if (clk_en) begin
			if (sleep_enter && fifo_hold_on_sleep && fifo_on) begin
				hold_error <= 1'b1;
			end else if (!fifo_on || count == '0) begin
				hold_error <= 1'b0;
			end
		end
	end

	// current sample and its ready bit; a new sample beats a read clear
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cur_sample <= '0;
			data_ready <= 1'b0;
		end else if (clk_en) begin
			if (tick) begin
				cur_sample <= sample_in;
				data_ready <= 1'b1;
			end else if (bus.rd && ptr >= `ASFR_X_HIGH_ADDR && ptr <= `ASFR_Z_LOW_ADDR) begin
				data_ready <= 1'b0;
			end
		end
	end

	// read decode and auto-increment
	always_comb begin
		rd_byte = 8'h00;
		do_pop = 1'b0;
		next_idx = idx;
		next_ptr = ptr + 8'h01;
		stream = fifo_on && ptr == `ASFR_X_HIGH_ADDR;
		if (fast_read_sel && (ptr == `ASFR_X_HIGH_ADDR || ptr == `ASFR_Y_HIGH_ADDR)) begin
			next_ptr = ptr + 8'h02;
		end
		if (stream) begin
			next_ptr = ptr;
			if (idx == 3'd0) begin
				do_pop = head_valid;
				rd_byte = head_valid ? pick(head, 3'd0) : 8'h00;
				next_idx = head_valid ? (fast_read_sel ? 3'd2 : 3'd1) : 3'd0;
			end else begin
				rd_byte = pick(frame, idx);
				if (idx == (fast_read_sel ? `ASFR_BYTES_FAST : `ASFR_BYTES_FULL)) begin
					next_idx = 3'd0;
				end else begin
					next_idx = idx + (fast_read_sel ? 3'd2 : 3'd1);
				end
			end
		end else begin
			unique case (ptr)
				`ASFR_STATUS_ADDR: begin
					rd_byte = fifo_on ? {overflow_flag, watermark_flag, fifo_count}
						: {4'h0, {4{data_ready}}};
				end
				`ASFR_X_HIGH_ADDR, `ASFR_X_LOW_ADDR, `ASFR_Y_HIGH_ADDR,
				`ASFR_Y_LOW_ADDR, `ASFR_Z_HIGH_ADDR, `ASFR_Z_LOW_ADDR: begin
					rd_byte = fifo_on ? 8'h00 : pick(cur_sample, 3'(ptr - 8'h01));
				end
				`ASFR_SETUP_ADDR: begin
					rd_byte = setup;
				end
				default: begin
					rd_byte = 8'h00;
				end
			endcase
		end
	end

	// address pointer and frame index; a new burst drops any half-read frame
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr <= 8'h00;
			idx <= 3'd0;
		end else if (clk_en) begin
			if (bus.start) begin
				ptr <= bus.addr;
				idx <= 3'd0;
			end else if (bus.rd || bus.wr) begin
				ptr <= next_ptr;
				if (bus.rd) begin
					idx <= next_idx;
				end
			end
			if (flush) begin
				idx <= 3'd0;
			end
		end
	end

	// popped sample is kept for the remaining bytes of its frame
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			frame <= '0;
		end else if (clk_en && host_pop) begin
			frame <= head;
		end
	end

	// registered read answer
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else if (clk_en) begin
			rd_valid <= bus.rd;
			if (bus.rd) begin
				rd_data <= rd_byte;
			end
		end
	end
endmodule : asfr_readout
`default_nettype wire

/* dv/asfr_readout_sva.sv */
// port assertions of the sample readout block
`timescale 1ns/100ps
`default_nettype none
module asfr_readout_sva #(
	parameter int DEPTH = 32
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire asfr_pkg::asfr_bus_t bus,
	input wire logic rd_valid,
	input wire logic active_rate_tick,
	input wire logic sleep_rate_tick,
	input wire logic auto_sleep,
	input wire logic active_mode,
	input wire logic push_stall,
	input wire logic overflow_flag,
	input wire logic watermark_flag,
	input wire logic hold_error,
	input wire logic [5:0] fifo_count
);
	import asfr_pkg::*;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	// full, then not flushed on the next edge
	sequence s_full;
		clk_en && fifo_count == DEPTH ##1 fifo_count != 0;
	endsequence
	// count grew by one over one enabled edge
	sequence s_grow;
		clk_en ##1 fifo_count == $past(fifo_count) + 6'd1;
	endsequence
	AST_GROW_TICK: assert property (s_grow |-> $past(active_rate_tick | sleep_rate_tick))
		else $error("count rose without a rate tick");
	AST_STEP: assert property (clk_en |=> fifo_count == 0 ||
		fifo_count - $past(fifo_count) inside {6'd0, 6'd1, 6'h3f})
		else $error("count moved by more than one");
	AST_OVF: assert property (s_full |-> overflow_flag)
		else $error("overflow flag missing at full");
	AST_WM_EMPTY: assert property (clk_en && fifo_count == 0 |=> !watermark_flag)
		else $error("watermark flag with empty buffer");
	AST_STALL_FULL: assert property (push_stall |-> fifo_count == DEPTH)
		else $error("stall below full");
	AST_STALL_KEEP: assert property (push_stall && clk_en && !bus.rd && !bus.wr
		&& $stable(auto_sleep) && $stable(active_mode) |=> fifo_count == DEPTH)
		else $error("refused sample changed the count");
	AST_HOLD: assert property (hold_error && clk_en |=> fifo_count <= $past(fifo_count))
		else $error("buffer grew during hold");
	AST_RD_ANSWER: assert property (clk_en && !bus.start |=> rd_valid == $past(bus.rd))
		else $error("read answer not one cycle later");
endmodule : asfr_readout_sva
bind asfr_readout asfr_readout_sva #(.DEPTH(DEPTH)) asfr_readout_sva_inst (
	.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus), .rd_valid(rd_valid),
	.active_rate_tick(active_rate_tick), .sleep_rate_tick(sleep_rate_tick),
	.auto_sleep(auto_sleep), .active_mode(active_mode),
	.push_stall(push_stall), .overflow_flag(overflow_flag), .watermark_flag(watermark_flag),
	.hold_error(hold_error), .fifo_count(fifo_count)
);
`default_nettype wire

/* dv/asfr_host.sv */
// host model issuing byte accesses on the register front end
`timescale 1ns/100ps
`default_nettype none
module asfr_host (
	input wire logic mclk,
	output var asfr_pkg::asfr_bus_t bus,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	import asfr_pkg::*;
	initial bus = '0;
	// one-cycle request launched just after an edge, then idle
	task automatic send(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) bus <= {k, a, d};
		@(posedge mclk) bus <= '0;
	endtask : send
	// start at an address and read n bytes; a missing answer reads as unknown
	task automatic burst(input logic [7:0] a, input int n, output logic [7:0] b [6]);
		send(3'b100, a, 8'h00);
		for (int k = 0; k < n; k++) begin
			send(3'b010, 8'h00, 8'h00);
			#1 b[k] = rd_valid ? rd_data : 8'hxx;
		end
	endtask : burst
	// write one byte at an address
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		send(3'b100, a, 8'h00);
		send(3'b001, 8'h00, d);
	endtask : wr
endmodule : asfr_host
`default_nettype wire

/* dv/asfr_readout_test.sv */
// self-checking bench of the sample readout path
`timescale 1ns/100ps
`default_nettype none
module asfr_readout_test;
	import asfr_pkg::*;
	logic mclk = 0, sys_rst = 1, art = 0, srt = 0, asl = 0, act = 0, hos = 0, fast = 0, trg = 0;
	logic rd_valid, stall, ovf, wm, herr, st;
	logic ce = 1;
	logic [7:0] rd_data;
	logic [7:0] bb [6];
	logic [5:0] cnt;
	asfr_sample_t smp = '0, cur;
	asfr_bus_t bus;
	asfr_sample_t q [$];
	int n_fail = 0, samples_checked = 0, cap = 32, i;
	bit circ = 1;
	// clock
	always #5 mclk = ~mclk;
	asfr_readout asfr_readout_inst (
		.mclk(mclk), .sys_rst(sys_rst), .clk_en(ce), .bus(bus), .rd_data(rd_data),
		.rd_valid(rd_valid), .sample_in(smp), .active_rate_tick(art), .sleep_rate_tick(srt),
		.auto_sleep(asl), .active_mode(act), .fifo_hold_on_sleep(hos), .fast_read_sel(fast),
		.trig_pulse(trg), .push_stall(stall), .overflow_flag(ovf), .watermark_flag(wm),
		.hold_error(herr), .fifo_count(cnt)
	);
	asfr_host asfr_host_inst (.mclk(mclk), .bus(bus), .rd_data(rd_data), .rd_valid(rd_valid));
	// expected burst byte k: high byte bits 13:6, low bits 5:0 moved up
	function automatic logic [7:0] exp_b(input asfr_sample_t s, input int k);
		logic [13:0] v;
		v = (k < 2) ? s.x : (k < 4) ? s.y : s.z;
		return k[0] ? {v[5:0], 2'b00} : v[13:6];
	endfunction : exp_b
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt
	// random sample on the active (sl=0) or sleep tick; model drops oldest or newest at cap
	task automatic push(input bit sl);
		logic [63:0] r;
		r = {$urandom, $urandom};
		@(posedge mclk);
		smp <= r[41:0];
		art <= !sl;
		srt <= sl;
		cur = r[41:0];
		if (q.size() == cap && circ)
			q.delete(0);
		if (q.size() < cap)
			q.push_back(cur);
		#1 st = stall;
		@(posedge mclk);
		art <= 0;
		srt <= 0;
	endtask : push
	task automatic cchk(input int n);
		wt(2);
		chk({2'b00, cnt}, n[7:0]);
	endtask : cchk
	// burst from the head; the model loses the popped frame whatever was read
	task automatic head(input int n, input int stp);
		asfr_host_inst.burst(8'h01, n, bb);
		for (int k = 0; k < n; k++)
			chk(bb[k], exp_b(q[0], k * stp));
		q.delete(0);
	endtask : head
	// setup rewritten in standby through off; going active flushes
	task automatic set_mode(input logic [7:0] v);
		@(posedge mclk) act <= 0;
		asfr_host_inst.wr(8'h09, 8'h00);
		asfr_host_inst.wr(8'h09, v);
		@(posedge mclk) act <= 1;
		wt(3);
		q.delete();
	endtask : set_mode
	task automatic end_sim;
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// watchdog against a hung sequence
	initial begin
		#300000;
		n_fail++;
		end_sim;
	end
	// main sequence
	initial begin
		void'($urandom(99739));
		repeat (6) @(posedge mclk);
		sys_rst <= 0;
		asfr_host_inst.burst(8'h09, 1, bb);
		chk(bb[0], 8'h00);
		asfr_host_inst.burst(8'h0a, 1, bb);
		chk(bb[0], 8'h00);
		// buffer off: registers follow the latest sample
		push(0);
		wt(2);
		asfr_host_inst.burst(8'h01, 6, bb);
		for (i = 0; i < 6; i++)
			chk(bb[i], exp_b(cur, i));
		@(posedge mclk) fast <= 1;
		asfr_host_inst.burst(8'h01, 3, bb);
		for (i = 0; i < 3; i++)
			chk(bb[i], exp_b(cur, 2 * i));
		asfr_host_inst.burst(8'h04, 1, bb);
		chk(bb[0], exp_b(cur, 3));
		@(posedge mclk) fast <= 0;
		// circular, mark 4, two beyond full
		set_mode(8'h44);
		asfr_host_inst.burst(8'h09, 1, bb);
		chk(bb[0], 8'h44);
		for (i = 1; i <= 34; i++) begin
			push(0);
			cchk(q.size());
			chk({7'd0, wm}, {7'd0, i >= 4});
		end
		chk({7'd0, ovf}, 8'h01);
		// status then head in one burst: overflow, watermark, count 32
		asfr_host_inst.burst(8'h00, 2, bb);
		chk(bb[0], 8'he0);
		chk(bb[1], exp_b(q[0], 0));
		q.delete(0);
		head(6, 1);
		asfr_host_inst.burst(8'h02, 1, bb);
		chk(bb[0], 8'h00);
		head(1, 1);
		head(1, 1);
		@(posedge mclk) fast <= 1;
		head(3, 2);
		@(posedge mclk) fast <= 0;
		cchk(q.size());
		set_mode(8'h00);
		chk({5'd0, ovf, wm, 1'b0} | {2'b00, cnt}, 8'h00);
		// stop on full, mark off
		set_mode(8'h80);
		circ = 0;
		repeat (33) push(0);
		chk({7'd0, st}, 8'h01);
		cchk(32);
		chk({7'd0, wm}, 8'h00);
		head(6, 1);
		// trigger: four kept before, then fill and stop
		set_mode(8'hc4);
		cap = 4;
		circ = 1;
		repeat (6) push(0);
		cchk(4);
		@(posedge mclk) trg <= 1;
		@(posedge mclk) trg <= 0;
		cap = 32;
		circ = 0;
		repeat (30) push(0);
		chk({7'd0, st}, 8'h01);
		cchk(32);
		head(6, 1);
		// rate change flushes; sleep tick feeds while asleep
		set_mode(8'h40);
		repeat (3) push(0);
		// only the standby to active edge flushes
		@(posedge mclk) act <= 0;
		cchk(3);
		@(posedge mclk) act <= 1;
		cchk(0);
		q.delete();
		repeat (3) push(0);
		@(posedge mclk) asl <= 1;
		cchk(0);
		q.delete();
		push(1);
		push(0);
		void'(q.pop_back());
		cchk(1);
		// clock enable low: the tick is ignored, the count frozen
		@(posedge mclk) ce <= 0;
		push(1);
		void'(q.pop_back());
		cchk(1);
		@(posedge mclk) ce <= 1;
		@(posedge mclk) asl <= 0;
		hos <= 1;
		q.delete();
		push(0);
		push(0);
		@(posedge mclk) asl <= 1;
		cchk(2);
		chk({7'd0, herr}, 8'h01);
		push(1);
		void'(q.pop_back());
		cchk(2);
		head(6, 1);
		head(6, 1);
		cchk(0);
		chk({7'd0, herr}, 8'h00);
		// emptied buffer takes samples again
		push(1);
		cchk(1);
		end_sim;
	end
endmodule : asfr_readout_test
`default_nettype wire
